/* rtl/trim_pkg.sv */
// constants for the self-test trim register bank
// assumes a 32-bit avalon-mm slave, one register per aligned word
package trim_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_TRIM_X = 7'h0D;
	localparam logic [6:0] IDX_TRIM_Y = 7'h0E;
	localparam logic [6:0] IDX_TRIM_Z = 7'h0F;
	localparam logic [6:0] IDX_TRIM_A = 7'h10;
	localparam logic [6:0] IDX_GYRO_CFG = 7'h1B;
	localparam logic [6:0] IDX_ACCEL_CFG = 7'h1C;
	localparam logic [6:0] IDX_ACCEL_FIRST = 7'h3B;
	localparam logic [6:0] IDX_ACCEL_LAST = 7'h40;
	localparam logic [6:0] IDX_GYRO_FIRST = 7'h43;
	localparam logic [6:0] IDX_GYRO_LAST = 7'h48;
	localparam int ADDR_W = 9;
	localparam int ADDR_LSB = 2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CHK_X_BIT = 7;
	localparam int CHK_Y_BIT = 6;
	localparam int CHK_Z_BIT = 5;
	localparam int FS_LSB = 3;
	localparam int HPF_LSB = 0;
	localparam int ACCEL_HI_LSB = 5;
	localparam int GYRO_CODE_LSB = 0;
	localparam int ACC_LO_X_LSB = 4;
	localparam int ACC_LO_Y_LSB = 2;
	localparam int ACC_LO_Z_LSB = 0;
	localparam logic [7:0] GYRO_CFG_MASK = 8'hF8;
	localparam logic [7:0] ACCEL_CFG_MASK = 8'hFF;

	// ------------------------------------------------------------
	// reset values and default factory codes
	// ------------------------------------------------------------
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [4:0] DEF_CODE = 5'h10;

	// bus handshake state, gray coded
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} bus_e;
endpackage : trim_pkg

/* rtl/trim_if.sv */
// carrier for the four trim bytes from store to register bank
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface trim_if;
	logic [7:0] trim_x_axis;
	logic [7:0] trim_y_axis;
	logic [7:0] trim_z_axis;
	logic [7:0] trim_accel_low_bits;

	modport store
	(
		output trim_x_axis,
		output trim_y_axis,
		output trim_z_axis,
		output trim_accel_low_bits
	);
	modport bank
	(
		input trim_x_axis,
		input trim_y_axis,
		input trim_z_axis,
		input trim_accel_low_bits
	);
endinterface : trim_if

/* rtl/trim_store.sv */
// factory trim store: packs six 5-bit codes into four register bytes
// assumes factory codes arrive as parameters; no write path exists
`timescale 1ns/1ns
module trim_store #(
	parameter logic [4:0] GYRO_X_TRIM_CODE = trim_pkg::DEF_CODE,
	parameter logic [4:0] GYRO_Y_TRIM_CODE = trim_pkg::DEF_CODE,
	parameter logic [4:0] GYRO_Z_TRIM_CODE = trim_pkg::DEF_CODE,
	parameter logic [4:0] ACCEL_X_TRIM_CODE = trim_pkg::DEF_CODE,
	parameter logic [4:0] ACCEL_Y_TRIM_CODE = trim_pkg::DEF_CODE,
	parameter logic [4:0] ACCEL_Z_TRIM_CODE = trim_pkg::DEF_CODE
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	trim_if.store trim
);
	typedef struct packed
	{
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] z;
		logic [7:0] a;
	} store_s;

	store_s state_r;
	store_s state_nxt;
	store_s factory;

	// ------------------------------------------------------------
	// byte packing
	// ------------------------------------------------------------
	// accel upper bits over gyro code, accel low bits gathered
	always_comb
	begin
		factory = '0;
		factory.x[trim_pkg::ACCEL_HI_LSB +: 3] = ACCEL_X_TRIM_CODE[4:2];
		factory.y[trim_pkg::ACCEL_HI_LSB +: 3] = ACCEL_Y_TRIM_CODE[4:2];
		factory.z[trim_pkg::ACCEL_HI_LSB +: 3] = ACCEL_Z_TRIM_CODE[4:2];
		factory.x[trim_pkg::GYRO_CODE_LSB +: 5] = GYRO_X_TRIM_CODE;
		factory.y[trim_pkg::GYRO_CODE_LSB +: 5] = GYRO_Y_TRIM_CODE;
		factory.z[trim_pkg::GYRO_CODE_LSB +: 5] = GYRO_Z_TRIM_CODE;
		factory.a[trim_pkg::ACC_LO_X_LSB +: 2] = ACCEL_X_TRIM_CODE[1:0];
		factory.a[trim_pkg::ACC_LO_Y_LSB +: 2] = ACCEL_Y_TRIM_CODE[1:0];
		factory.a[trim_pkg::ACC_LO_Z_LSB +: 2] = ACCEL_Z_TRIM_CODE[1:0];
		state_nxt = state_r;
		if (rst_i)
		begin
			state_nxt = factory;
		end
	end

	// state register, reloaded from factory values on reset
	always_ff @(posedge sys_clk_i)
	begin
		state_r <= rst_i ? factory : state_nxt;
	end

	assign trim.trim_x_axis = state_r.x;
	assign trim.trim_y_axis = state_r.y;
	assign trim.trim_z_axis = state_r.z;
	assign trim.trim_accel_low_bits = state_r.a;
endmodule : trim_store

/* rtl/self_test_trim_registers.sv */
// self-test trim register bank with self-test control and data readback
// assumes avalon-mm master on sys_clk_i, sensor words from same-clock logic
`timescale 1ns/1ns
// Summary of operation
// - four byte registers at 0x0D..0x10 hold factory self-test trim codes
// - bytes 0x0D..0x0F carry gyro x, y, z 5-bit codes in bits 4:0
// - accel codes: top three bits in 7:5, low pairs packed into 0x10
// - gyro check bits actuate that axis; shifted data readable at 67..72
// - accel check bits actuate that axis; shifted data readable at 59..64
// - three gyro check bits in register 27, singly or together
// - three accel check bits in register 28, singly or together
module self_test_trim_registers
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [8:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [15:0] accel_x_data_i,
	input wire logic [15:0] accel_y_data_i,
	input wire logic [15:0] accel_z_data_i,
	input wire logic [15:0] gyro_x_data_i,
	input wire logic [15:0] gyro_y_data_i,
	input wire logic [15:0] gyro_z_data_i,
	output logic gyro_x_check_on,
	output logic gyro_y_check_on,
	output logic gyro_z_check_on,
	output logic accel_x_check_on,
	output logic accel_y_check_on,
	output logic accel_z_check_on,
	output logic [1:0] gyro_range_o,
	output logic [1:0] accel_range_o,
	output logic [2:0] accel_hpf_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		trim_pkg::bus_e bus;
		logic [31:0] rdata;
		logic [7:0] gyro_cfg;
		logic [7:0] accel_cfg;
		logic [5:0][15:0] meas;
	} bank_s;

	bank_s state_r;
	bank_s state_nxt;
	logic [6:0] idx;
	logic req;
	logic [6:0] rel;
	logic [7:0] rbyte;
	logic gyro_cfg_hit;
	logic accel_cfg_hit;

	trim_if trim();

	// ------------------------------------------------------------
	// factory trim store
	// ------------------------------------------------------------
	trim_store u_store
	(
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.trim(trim)
	);

	// high byte sits at the odd index (even offset in the window), low byte at the even one
	function automatic logic [7:0] word_byte(input logic [15:0] w, input logic low);
		word_byte = low ? w[7:0] : w[15:8];
	endfunction : word_byte

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// true when an index lies inside a measurement window, ends included
	function automatic logic in_window(input logic [6:0] i, input logic [6:0] first,
		input logic [6:0] last);
		in_window = (i >= first) && (i <= last);
	endfunction : in_window

	// write strobe for one byte-wide control register, lane 0 only
	function automatic logic cfg_hit(input logic [6:0] i, input logic [6:0] target,
		input logic wr, input logic lane0);
		cfg_hit = wr && lane0 && (i == target);
	endfunction : cfg_hit

	// ------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------
	// word index from the byte address; low address bits ignored
	assign idx = avs_address_i[trim_pkg::ADDR_LSB +: 7];
	assign req = avs_read_i | avs_write_i;

	// control writes; trim and measurement indices never match
	assign gyro_cfg_hit = cfg_hit(idx, trim_pkg::IDX_GYRO_CFG, avs_write_i,
		avs_byteenable_i[0]);
	assign accel_cfg_hit = cfg_hit(idx, trim_pkg::IDX_ACCEL_CFG, avs_write_i,
		avs_byteenable_i[0]);

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	// unmapped indices read as zero
	always_comb
	begin
		rel = 7'h00;
		rbyte = 8'h00;
		if (in_window(idx, trim_pkg::IDX_ACCEL_FIRST, trim_pkg::IDX_ACCEL_LAST))
		begin
			rel = idx - trim_pkg::IDX_ACCEL_FIRST;
			rbyte = word_byte(state_r.meas[rel[2:1]], rel[0]);
		end
		else if (in_window(idx, trim_pkg::IDX_GYRO_FIRST, trim_pkg::IDX_GYRO_LAST))
		begin
			rel = idx - trim_pkg::IDX_GYRO_FIRST;
			rbyte = word_byte(state_r.meas[3 + rel[2:1]], rel[0]);
		end
		else
		begin
			unique case (idx)
				trim_pkg::IDX_TRIM_X: rbyte = trim.trim_x_axis;
				trim_pkg::IDX_TRIM_Y: rbyte = trim.trim_y_axis;
				trim_pkg::IDX_TRIM_Z: rbyte = trim.trim_z_axis;
				trim_pkg::IDX_TRIM_A: rbyte = trim.trim_accel_low_bits;
				trim_pkg::IDX_GYRO_CFG: rbyte = state_r.gyro_cfg;
				trim_pkg::IDX_ACCEL_CFG: rbyte = state_r.accel_cfg;
				default: rbyte = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// one wait cycle per access; write lands on the acknowledging edge
	always_comb
	begin
		state_nxt = state_r;
		// sensor words sampled every cycle, no snapshot across bytes
		state_nxt.meas[0] = accel_x_data_i;
		state_nxt.meas[1] = accel_y_data_i;
		state_nxt.meas[2] = accel_z_data_i;
		state_nxt.meas[3] = gyro_x_data_i;
		state_nxt.meas[4] = gyro_y_data_i;
		state_nxt.meas[5] = gyro_z_data_i;
		unique case (state_r.bus)
			trim_pkg::BUS_IDLE:
			begin
				if (req)
				begin
					state_nxt.bus = trim_pkg::BUS_ACK;
					state_nxt.rdata = {24'h000000, rbyte};
				end
			end
			trim_pkg::BUS_ACK:
			begin
				state_nxt.bus = trim_pkg::BUS_IDLE;
				// trim indices have no write path
				if (gyro_cfg_hit)
				begin
					state_nxt.gyro_cfg = avs_writedata_i[7:0] & trim_pkg::GYRO_CFG_MASK;
				end
				if (accel_cfg_hit)
				begin
					state_nxt.accel_cfg = avs_writedata_i[7:0] & trim_pkg::ACCEL_CFG_MASK;
				end
			end
			default:
			begin
				state_nxt.bus = trim_pkg::BUS_IDLE;
			end
		endcase
	end

	// state register with synchronous reset
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_r.bus <= trim_pkg::BUS_IDLE;
			state_r.rdata <= trim_pkg::RDATA_RESET;
			state_r.gyro_cfg <= trim_pkg::CFG_RESET;
			state_r.accel_cfg <= trim_pkg::CFG_RESET;
			state_r.meas <= '0;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// bus outputs
	// ------------------------------------------------------------
	// exactly one wait cycle: while a request is held, low only in the acknowledging cycle; also low with no request
	assign avs_waitrequest_o = req && state_r.bus == trim_pkg::BUS_IDLE;
	// read data stands until the next request is taken
	assign avs_readdata_o = state_r.rdata;

	// ------------------------------------------------------------
	// self-test control outputs
	// ------------------------------------------------------------
	// actuation per axis, independently or together
	assign gyro_x_check_on = state_r.gyro_cfg[trim_pkg::CHK_X_BIT];
	assign gyro_y_check_on = state_r.gyro_cfg[trim_pkg::CHK_Y_BIT];
	assign gyro_z_check_on = state_r.gyro_cfg[trim_pkg::CHK_Z_BIT];
	assign accel_x_check_on = state_r.accel_cfg[trim_pkg::CHK_X_BIT];
	assign accel_y_check_on = state_r.accel_cfg[trim_pkg::CHK_Y_BIT];
	assign accel_z_check_on = state_r.accel_cfg[trim_pkg::CHK_Z_BIT];
	assign gyro_range_o = state_r.gyro_cfg[trim_pkg::FS_LSB +: 2];
	assign accel_range_o = state_r.accel_cfg[trim_pkg::FS_LSB +: 2];
	assign accel_hpf_o = state_r.accel_cfg[trim_pkg::HPF_LSB +: 3];
endmodule : self_test_trim_registers

/* verification/trim_monitor.sv */
// bus and control checks for the self-test trim register bank
// assumes default factory codes in the trim store
`timescale 1ns/1ns
module trim_monitor
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [8:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic gyro_x_check_on,
	input wire logic gyro_y_check_on,
	input wire logic gyro_z_check_on,
	input wire logic accel_x_check_on,
	input wire logic accel_y_check_on,
	input wire logic accel_z_check_on,
	input wire logic [1:0] gyro_range_o
);
	localparam logic [4:0] C = trim_pkg::DEF_CODE;
	localparam logic [7:0] T_AX = {C[4:2], C};
	localparam logic [7:0] T_LO = {2'b00, C[1:0], C[1:0], C[1:0]};
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	wire done = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	wire [6:0] idx = avs_address_i[8:2];
	wire [2:0] g = {gyro_x_check_on, gyro_y_check_on, gyro_z_check_on};
	wire [2:0] a = {accel_x_check_on, accel_y_check_on, accel_z_check_on};
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_one_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
	property p_trim_x;
		avs_read_i && done && idx == 7'h0D |-> avs_readdata_o == {24'h0, T_AX};
	endproperty
	a_trim_x: assert property (p_trim_x) else $error("x trim byte wrong");
	property p_trim_yz;
		avs_read_i && done && (idx == 7'h0E || idx == 7'h0F) |-> avs_readdata_o[7:0] == T_AX;
	endproperty
	a_trim_yz: assert property (p_trim_yz) else $error("y or z trim byte wrong");
	property p_trim_a;
		avs_read_i && done && idx == 7'h10 |-> avs_readdata_o == {24'h0, T_LO};
	endproperty
	a_trim_a: assert property (p_trim_a) else $error("accel low trim byte wrong");
	property p_unmapped;
		avs_read_i && done && idx == 7'h00 |-> avs_readdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_gcheck;
		avs_write_i && done && idx == trim_pkg::IDX_GYRO_CFG && avs_byteenable_i[0]
		|=> g == $past(avs_writedata_i[7:5]) && gyro_range_o == $past(avs_writedata_i[4:3]);
	endproperty
	a_gcheck: assert property (p_gcheck) else $error("gyro check bits wrong");
	property p_acheck;
		avs_write_i && done && idx == trim_pkg::IDX_ACCEL_CFG && avs_byteenable_i[0]
		|=> a == $past(avs_writedata_i[7:5]);
	endproperty
	a_acheck: assert property (p_acheck) else $error("accel check bits wrong");
	property p_hold;
		!(avs_write_i && done) |=> $stable({g, a});
	endproperty
	a_hold: assert property (p_hold) else $error("check bits moved");
	property p_rst;
		$fell(rst_i) |-> {g, a} == 6'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("check bits not cleared");
endmodule : trim_monitor
bind self_test_trim_registers trim_monitor mon_u (.*);

/* verification/self_test_trim_registers_tb.sv */
// self-checking bench for the self-test trim register bank
// assumes default factory codes and one wait cycle per access
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", n, e, s); end end
module self_test_trim_registers_tb;
	logic clk = 0, rst = 1, rd = 0, wr = 0;
	logic [8:0] adr = '0;
	logic [31:0] wd = '0, rdat;
	logic [3:0] be = 4'hF;
	logic [15:0] sd [6] = '{default: 16'h0};
	wire [31:0] rdo;
	wire wt;
	wire [5:0] chk;
	wire [1:0] gr, ar;
	wire [2:0] hpf;
	int fail_count = 0, comparisons = 0;
	localparam logic [4:0] C = trim_pkg::DEF_CODE;
	self_test_trim_registers dut_u (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdo), .avs_waitrequest_o(wt), .accel_x_data_i(sd[0]),
		.accel_y_data_i(sd[1]), .accel_z_data_i(sd[2]), .gyro_x_data_i(sd[3]),
		.gyro_y_data_i(sd[4]), .gyro_z_data_i(sd[5]), .gyro_x_check_on(chk[5]),
		.gyro_y_check_on(chk[4]), .gyro_z_check_on(chk[3]), .accel_x_check_on(chk[2]),
		.accel_y_check_on(chk[1]), .accel_z_check_on(chk[0]), .gyro_range_o(gr),
		.accel_range_o(ar), .accel_hpf_o(hpf));
	// clock
	initial forever #10 clk = ~clk;
	// one bus access, held until waitrequest low
	task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
		@(posedge clk);
		adr <= {i, 2'b00};
		wd <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do
			@(posedge clk);
		while (wt !== 1'b0);
		rdat = rdo;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	// trim bytes survive writes
	task automatic t_trim(input logic [7:0] wv);
		logic [7:0] ex [4] = '{{C[4:2], C}, {C[4:2], C}, {C[4:2], C}, {2'b00, {3{C[1:0]}}}};
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, 7'(13 + i), wv);
			bus(1'b0, 7'(13 + i), 8'h00);
			`CHK("trim", {24'h0, ex[i]}, rdat)
		end
		bus(1'b0, 7'h00, 8'h00);
		`CHK("unmapped", 32'h0, rdat)
		$display("trim test done");
	endtask : t_trim
	// every check-bit combination, range, readback
	task automatic t_cfg(input logic [6:0] i, input logic [1:0] r, input logic [2:0] lo);
		for (int v = 0; v < 8; v++)
		begin
			bus(1'b1, i, {v[2:0], r, 3'b101});
			@(negedge clk);
			`CHK("check", v[2:0], (i == trim_pkg::IDX_GYRO_CFG) ? chk[5:3] : chk[2:0])
			`CHK("range", r, (i == trim_pkg::IDX_GYRO_CFG) ? gr : ar)
			bus(1'b0, i, 8'h00);
			`CHK("cfg", {24'h0, v[2:0], r, lo}, rdat)
		end
		$display("config test done");
	endtask : t_cfg
	// measurement words in two passes, check bits on in both (left on by t_cfg, then rewritten)
	task automatic t_data;
		logic [7:0] h;
		logic [6:0] j;
		logic [15:0] base [6];
		for (int p = 0; p < 2; p++)
		begin
			if (p == 1)
				bus(1'b1, trim_pkg::IDX_GYRO_CFG, 8'hE0);
			if (p == 1)
				bus(1'b1, trim_pkg::IDX_ACCEL_CFG, 8'hF0);
			@(posedge clk);
			foreach (sd[a]) sd[a] <= 16'(16'h1020 + 16'h0100 * a + 16'h0055 * p);
			for (int a = 0; a < 6; a++)
			begin
				j = (a < 3) ? 7'(59 + 2 * a) : 7'(67 + 2 * (a - 3));
				bus(1'b0, j, 8'h00);
				h = rdat[7:0];
				bus(1'b0, j + 7'h1, 8'h00);
				`CHK("meas", 16'(16'h1020 + 16'h0100 * a + 16'h0055 * p), {h, rdat[7:0]})
				if (p == 0)
					base[a] = {h, rdat[7:0]};
				else
					`CHK("resp", 16'h0055, 16'({h, rdat[7:0]} - base[a]))
			end
		end
		$display("data test done");
	endtask : t_data
	// a write without byte lane 0 is dropped
	task automatic t_be;
		be <= 4'h0;
		bus(1'b1, trim_pkg::IDX_GYRO_CFG, 8'h00);
		be <= 4'hF;
		bus(1'b0, trim_pkg::IDX_GYRO_CFG, 8'h00);
		`CHK("lane", 32'h0000_00E0, rdat)
		$display("lane test done");
	endtask : t_be
	// verdict
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_trim(8'hFF);
		t_cfg(trim_pkg::IDX_GYRO_CFG, 2'h0, 3'h0);
		t_cfg(trim_pkg::IDX_ACCEL_CFG, 2'h2, 3'h5);
		`CHK("hpf", 3'h5, hpf)
		t_data();
		t_be();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK("rst check", 6'h00, chk)
		t_trim(8'h00);
		close_out();
	end
endmodule : self_test_trim_registers_tb
